// ==== hdl/fmt_timer.v ====
// Overview of operation
// - four modes: pulse, off delay, shot, min-on
// - pulse: rising edge starts fixed pulse
// - pulse: retrigger clears elapsed, extends pulse
// - pulse: triggered flag equals output
// - off delay: rising edge forces output low
// - off delay: short input gives one-tick pulse
// - off delay: expiry with input high, output high
// - off delay: flag set on rise, clears after
// - one shot: nonzero time write starts output
// - one shot: time counts down, zero clears
// - one shot: time rewritable while counting
// - one shot: no reload after reaching zero
// - one shot: input gates countdown and output
// - min-on: rising edge drives output high
// - min-on: falling edge starts count, expiry low
// - min-on: re-rise resets elapsed to zero
// - min-on: flag while elapsed above zero
//
// Purpose: interval timer with four modes behind AXI4-Lite
// Assumes: inputs synchronous to aclk, one write and one read at a time
// Notes:   time and elapsed count in 110 ms sample ticks
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "fmt_timer_regs.vh"

module fmt_timer #(
  parameter TW         = 32,
  parameter SAMPLE_CYC = `FMT_SAMPLE_CYC
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          trig_in,
  input  wire [3:0]    s_axi_awaddr,
  input  wire          s_axi_awvalid,
  output reg           s_axi_awready,
  input  wire [31:0]   s_axi_wdata,
  input  wire [3:0]    s_axi_wstrb,
  input  wire          s_axi_wvalid,
  output reg           s_axi_wready,
  output reg  [1:0]    s_axi_bresp,
  output reg           s_axi_bvalid,
  input  wire          s_axi_bready,
  input  wire [3:0]    s_axi_araddr,
  input  wire          s_axi_arvalid,
  output reg           s_axi_arready,
  output reg  [31:0]   s_axi_rdata,
  output reg  [1:0]    s_axi_rresp,
  output reg           s_axi_rvalid,
  input  wire          s_axi_rready,
  output reg           timer_out_ff,
  output reg           triggered_ff,
  output reg  [TW-1:0] elapsed_ff
);

  // ----------------------------------------------------------------
  // sample tick divider
  // ----------------------------------------------------------------
  reg  [31:0]   div_ff;
  reg           tick_ff;
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b0;
    end else if (div_ff == SAMPLE_CYC - 1) begin
      div_ff  <= 32'h0;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 32'h1;
      tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // register bus: write side
  // ----------------------------------------------------------------
  reg  [2:0]    ctrl_ff;
  reg  [TW-1:0] time_ff;
  reg  [TW-1:0] nxt_time;
  reg  [3:0]    awaddr_ff;
  reg           aw_hold_ff;
  reg  [31:0]   wdata_ff;
  reg  [3:0]    wstrb_ff;
  reg           w_hold_ff;
  reg           time_wr_ff;
  wire [1:0]    mode = ctrl_ff[`FMT_CTRL_MODE_HI:`FMT_CTRL_MODE_LO];
  wire          sw_in = ctrl_ff[`FMT_CTRL_IN_BIT];
  wire          in_now = trig_in | sw_in;
  wire          do_wr = aw_hold_ff & w_hold_ff & ~s_axi_bvalid;
  wire          wr_ok = (awaddr_ff == `FMT_OFS_CTRL) ||
                        (awaddr_ff == `FMT_OFS_TIME) ||
                        (awaddr_ff == `FMT_OFS_ELAPSED) ||
                        (awaddr_ff == `FMT_OFS_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FMT_RESP_OKAY;
      aw_hold_ff    <= 1'b0;
      w_hold_ff     <= 1'b0;
      awaddr_ff     <= 4'h0;
      wdata_ff      <= 32'h0;
      wstrb_ff      <= 4'h0;
      ctrl_ff       <= `FMT_CTRL_RST;
      time_wr_ff    <= 1'b0;
    end else begin
      time_wr_ff <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_ff     <= s_axi_awaddr;
        aw_hold_ff    <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_ff     <= s_axi_wdata;
        wstrb_ff     <= s_axi_wstrb;
        w_hold_ff    <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (do_wr) begin
        aw_hold_ff   <= 1'b0;
        w_hold_ff    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `FMT_RESP_OKAY : `FMT_RESP_SLVERR;
        if (awaddr_ff == `FMT_OFS_CTRL) begin
          if (wstrb_ff[0])
            ctrl_ff <= wdata_ff[2:0];
        end else if (awaddr_ff == `FMT_OFS_TIME) begin
          time_wr_ff <= 1'b1;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // byte-lane merge of a time write
  integer i;
  always @* begin
    nxt_time = time_ff;
    for (i = 0; i < 4; i = i + 1)
      if (wstrb_ff[i] && (8 * i < TW))
        nxt_time[8*i +: 8] = wdata_ff[8*i +: 8];
  end

  // ----------------------------------------------------------------
  // register bus: read side
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `FMT_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= `FMT_RESP_OKAY;
      if (s_axi_araddr == `FMT_OFS_CTRL)
        s_axi_rdata <= {29'h0, ctrl_ff};
      else if (s_axi_araddr == `FMT_OFS_TIME)
        s_axi_rdata <= time_ff;
      else if (s_axi_araddr == `FMT_OFS_ELAPSED)
        s_axi_rdata <= elapsed_ff;
      else if (s_axi_araddr == `FMT_OFS_STATUS)
        s_axi_rdata <= {30'h0, triggered_ff, timer_out_ff};
      else begin
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `FMT_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // timer core
  // ----------------------------------------------------------------
  reg           in_prev_ff;
  reg           running_ff;
  reg           pulse_ff;
  wire          rise = in_now & ~in_prev_ff;
  wire          fall = ~in_now & in_prev_ff;
  wire          done = (elapsed_ff >= time_ff);
  wire [TW-1:0] el_inc = elapsed_ff + {{(TW-1){1'b0}}, 1'b1};

  always @(posedge aclk) begin
    if (!aresetn) begin
      in_prev_ff   <= 1'b0;
      running_ff   <= 1'b0;
      pulse_ff     <= 1'b0;
      timer_out_ff <= 1'b0;
      triggered_ff <= 1'b0;
      elapsed_ff   <= {TW{1'b0}};
      time_ff      <= `FMT_TIME_RST;
    end else begin
      if (time_wr_ff) begin
        time_ff <= nxt_time;
        if (mode == `FMT_MODE_ONE_SHOT && nxt_time != {TW{1'b0}}) begin
          triggered_ff <= 1'b1;
          timer_out_ff <= in_now;
        end
      end else if (tick_ff) begin
        in_prev_ff <= in_now;
        case (mode)
          `FMT_MODE_ON_PULSE: begin
            if (rise) begin
              elapsed_ff   <= {TW{1'b0}};
              timer_out_ff <= 1'b1;
              triggered_ff <= 1'b1;
            end else if (timer_out_ff) begin
              if (el_inc >= time_ff) begin
                timer_out_ff <= 1'b0;
                triggered_ff <= 1'b0;
              end
              elapsed_ff <= el_inc;
            end
          end
          `FMT_MODE_OFF_DELAY: begin
            if (rise) begin
              timer_out_ff <= 1'b0;
              triggered_ff <= 1'b1;
              running_ff   <= 1'b1;
              pulse_ff     <= 1'b0;
              elapsed_ff   <= {TW{1'b0}};
            end else if (running_ff) begin
              if (el_inc >= time_ff) begin
                running_ff   <= 1'b0;
                timer_out_ff <= 1'b1;
                pulse_ff     <= ~in_now;
              end
              elapsed_ff <= el_inc;
            end else if (timer_out_ff) begin
              if (pulse_ff || !in_now) begin
                timer_out_ff <= 1'b0;
                pulse_ff     <= 1'b0;
                triggered_ff <= 1'b0;
              end
            end
          end
          `FMT_MODE_ONE_SHOT: begin
            if (time_ff != {TW{1'b0}} && triggered_ff) begin
              timer_out_ff <= in_now;
              if (in_now) begin
                time_ff <= time_ff - {{(TW-1){1'b0}}, 1'b1};
                elapsed_ff <= el_inc;
              end
            end else begin
              timer_out_ff <= 1'b0;
              triggered_ff <= 1'b0;
            end
          end
          default: begin
            if (rise) begin
              // rise sets; elapsed back to zero
              timer_out_ff <= 1'b1;
              running_ff   <= 1'b0;
              elapsed_ff   <= {TW{1'b0}};
              triggered_ff <= 1'b0;
            end else if (fall && timer_out_ff) begin
              running_ff   <= 1'b1;
              elapsed_ff   <= el_inc;
              triggered_ff <= 1'b1;
              // short set time: stay running so the next tick clears count
              if (el_inc >= time_ff)
                timer_out_ff <= 1'b0;
            end else if (running_ff) begin
              if (done) begin
                timer_out_ff <= 1'b0;
                running_ff   <= 1'b0;
                triggered_ff <= 1'b0;
                elapsed_ff   <= {TW{1'b0}};
              end else begin
                elapsed_ff <= el_inc;
                if (el_inc >= time_ff)
                  timer_out_ff <= 1'b0;
              end
            end else begin
              triggered_ff <= (elapsed_ff != {TW{1'b0}});
            end
          end
        endcase
      end
    end
  end

endmodule // fmt_timer

// ==== hdl/fmt_timer_regs.vh ====
// Purpose: constants for the four mode interval timer
// Assumes: 40 MHz aclk, 32-bit AXI4-Lite register bus
// Notes:   offsets are byte addresses of aligned words
`ifndef FMT_TIMER_REGS_VH
`define FMT_TIMER_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define FMT_OFS_CTRL     4'h0
`define FMT_OFS_TIME     4'h4
`define FMT_OFS_ELAPSED  4'h8
`define FMT_OFS_STATUS   4'hC

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define FMT_CTRL_MODE_LO 0
`define FMT_CTRL_MODE_HI 1
`define FMT_CTRL_IN_BIT  2
`define FMT_CTRL_RST     3'h0
`define FMT_TIME_RST     32'h0000_0000
`define FMT_STAT_OUT_BIT 0
`define FMT_STAT_TRG_BIT 1

// ----------------------------------------------------------------
// modes
// ----------------------------------------------------------------
`define FMT_MODE_ON_PULSE  2'h0
`define FMT_MODE_OFF_DELAY 2'h1
`define FMT_MODE_ONE_SHOT  2'h2
`define FMT_MODE_MIN_ON    2'h3

// ----------------------------------------------------------------
// timing and bus response codes
// ----------------------------------------------------------------
`define FMT_CLK_HZ       40000000
`define FMT_SAMPLE_MS    110
`define FMT_SAMPLE_CYC   ((`FMT_CLK_HZ / 1000) * `FMT_SAMPLE_MS)
`define FMT_RESP_OKAY    2'h0
`define FMT_RESP_SLVERR  2'h2

`endif

// ==== testbench/fmt_checker.sv ====
// Purpose: bus and timer checks on fmt_timer ports
// Assumes: write data offered together with its address
// Notes:   mode is tracked from control writes
`timescale 1ns/100ps
module fmt_checker #(parameter TW = 32) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic [3:0]    s_axi_awaddr,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wready,
  input wire logic [31:0]   s_axi_wdata,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          timer_out_ff,
  input wire logic          triggered_ff,
  input wire logic [TW-1:0] elapsed_ff
);
  reg [1:0] mode_ff;
  always @(posedge aclk)
    if (!aresetn) mode_ff <= 2'h0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 4'h0)
      mode_ff <= s_axi_wdata[1:0];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_w_answer: assert property (s_axi_awvalid && s_axi_awready
    |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  a_b_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  a_elapsed_step: assert property ($changed(elapsed_ff)
    |-> elapsed_ff == 0 || elapsed_ff == $past(elapsed_ff) + 1)
    else $error("elapsed jumped");
  a_elapsed_rate: assert property ($changed(elapsed_ff)
    |=> $stable(elapsed_ff)) else $error("elapsed moved twice");
  a_pulse_flag: assert property (mode_ff == 2'h0
    && $past(mode_ff, 4) == 2'h0 |-> triggered_ff == timer_out_ff)
    else $error("pulse flag differs from output");
  a_minon_flag: assert property (mode_ff == 2'h3
    && $past(mode_ff, 4) == 2'h3 |-> triggered_ff == (elapsed_ff != 0))
    else $error("min-on flag differs from count");
  cover property (mode_ff == 2'h1 && timer_out_ff);
  cover property (mode_ff == 2'h2 && triggered_ff);
  cover property (mode_ff == 2'h3 && elapsed_ff != 0);
endmodule // fmt_checker

// ==== testbench/fmt_ctl_model.sv ====
// Purpose: soft-wired source of the timer input
// Assumes: the bench sets the wanted level
// Notes:   the level reaches the timer one clock later
`timescale 1ns/100ps
module fmt_ctl_model (
  input  wire logic aclk,
  input  wire logic want,
  output logic      trig_in
);
  initial trig_in = 1'b0;
  always @(posedge aclk) trig_in <= want;
endmodule // fmt_ctl_model

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for fmt_timer
// Assumes: sample tick shortened to 8 clocks
// Notes:   expectations are counted in sample ticks
`timescale 1ns/100ps
module tb;
  localparam SC = 8;
  logic        aclk = 1'b0, aresetn = 1'b0, want = 1'b0, trig_in;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, elapsed_ff, d;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready;
  logic        s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        timer_out_ff, triggered_ff;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  int          miscompares = 0, num_checks = 0, seed = 32'hfc97fcd7, n, tm, a;
  always #12.5 aclk = ~aclk;
  fmt_timer #(.SAMPLE_CYC(SC)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .trig_in(trig_in),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .timer_out_ff(timer_out_ff),
    .triggered_ff(triggered_ff), .elapsed_ff(elapsed_ff));
  fmt_ctl_model i_ctl (.aclk(aclk), .want(want), .trig_in(trig_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d, miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic limit(input int k);
    if (k >= 50) begin
      miscompares++;
      conclude();
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [31:0] wd);
    int k;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_wdata <= wd;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && k < 50);
    s_axi_bready <= 1'b0;
    limit(k);
  endtask
  task automatic rd(input logic [3:0] ad, output logic [31:0] rv);
    int k;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && k < 50);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
    limit(k);
  endtask
  task automatic tk(input int k);
    repeat (k * SC) @(posedge aclk);
  endtask
  // status word: bit 1 triggered, bit 0 output
  task automatic st(input logic [1:0] e);
    rd(4'hC, d);
    check(d, {30'h0, e});
  endtask
  task automatic rst;
    aresetn <= 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
  endtask
  initial begin
    rst();
    for (int i = 0; i < 4; i++) begin
      rd(4'(i * 4), d);
      check(d, 32'h0);
    end
    rd(4'h6, d);
    check({30'h0, rr}, 32'h2);
    // on pulse: retrigger mid pulse stretches it
    wr(4'h4, 32'h6);
    want <= 1'b1;
    tk(2);
    st(2'b11);
    want <= 1'b0;
    tk(2);
    want <= 1'b1;
    tk(4);
    st(2'b11);
    rd(4'h8, d);
    check(d < 6, 1);
    tk(6);
    st(2'b00);
    want <= 1'b0;
    // off delay
    wr(4'h0, 32'h1);
    wr(4'h4, 32'h4);
    want <= 1'b1;
    tk(2);
    st(2'b10);
    tk(4);
    st(2'b11);
    want <= 1'b0;
    tk(2);
    st(2'b00);
    want <= 1'b1;
    tk(1);
    want <= 1'b0;
    n = 0;
    repeat (8 * SC) begin
      @(posedge aclk);
      n += timer_out_ff;
    end
    check(n, SC);
    // minimum on, random set time
    rst();
    wr(4'h0, 32'h3);
    tm = 3 + ($random(seed) & 3);
    wr(4'h4, tm);
    want <= 1'b1;
    tk(2);
    st(2'b01);
    want <= 1'b0;
    tk(2);
    st(2'b11);
    want <= 1'b1;
    tk(2);
    rd(4'h8, d);
    check(d, 32'h0);
    check(elapsed_ff, 32'h0);
    check(triggered_ff, 1'b0);
    want <= 1'b0;
    tk(tm - 1);
    st(2'b11);
    tk(4);
    st(2'b00);
    // one shot
    wr(4'h0, 32'h2);
    want <= 1'b1;
    tk(1);
    wr(4'h4, 32'h14);
    st(2'b11);
    wr(4'h4, 32'h3);
    tk(5);
    st(2'b00);
    tk(2);
    rd(4'h4, d);
    check(d, 32'h0);
    wr(4'h4, 32'hA);
    want <= 1'b0;
    tk(2);
    rd(4'h4, d);
    a = d;
    check(timer_out_ff, 1'b0);
    tk(2);
    rd(4'h4, d);
    check(d, a);
    want <= 1'b1;
    tk(13);
    st(2'b00);
    // one shot opened by the soft input bit alone
    want <= 1'b0;
    wr(4'h0, 32'h6);
    wr(4'h4, 32'h2);
    st(2'b11);
    tk(4);
    st(2'b00);
    conclude();
  end
endmodule // tb
bind fmt_timer fmt_checker #(.TW(TW)) i_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .timer_out_ff(timer_out_ff), .triggered_ff(triggered_ff),
  .elapsed_ff(elapsed_ff));
